// [inc/angle_postproc_defs.svh]
// register indices, field positions, reset values and timing figures
// assumes inclusion by bare name from the angle post-processing files
`ifndef ANGLE_POSTPROC_DEFS_SVH
`define ANGLE_POSTPROC_DEFS_SVH
// register indices, byte address is four times the index
`define IDX_SEC_LIN_LOW 8'h32
`define IDX_ENC_REPORT 8'h3D
`define IDX_PRIM_CFG 8'h3E
`define IDX_SEC_CFG 8'h3F
`define IDX_TURNS_STAT 8'h40
`define IDX_ENC_STAT 8'h41
`define CFG_RESET 26'h0000000
// encoder report register fields
`define F_COUNTUP_RPT 25
`define F_SLEW_DLY 24
`define F_FAULT_MODE 23:22
// per-channel configuration fields; the last one is in the secondary linearization low register
`define F_ENCODER_ANGLE_HYSTERESIS 25:23
`define F_CLK_SCALE 22:20
`define F_CAL_OFF 18
`define F_SLEEP 17:14
`define F_LIN_ON 13
`define F_INIT_SEL 12
`define F_DIR 11
`define F_MOTION_SEL 9
`define F_OFFSET 10:0
`define F_SPARE 25:20
`define F_ACC_RATE 19:18
`define F_SEC_HYST_OFF 12
// angle scaling: offset lsb is 16 lsb of the 16-bit angle
`define OFFSET_SHIFT 4
// 5.625 deg turns band in 16-bit angle lsb
`define TURNS_BAND 14'h0400
`define CLK_SCALE_REF 3'h7
// timing
`define CLK_PERIOD_NS 50
`define ACC_BASE_PERIOD_NS 1024000
`endif

// [inc/angle_postproc_pkg.sv]
// types shared by the angle post-processing design
// assumes nothing of its surroundings
package angle_postproc_pkg;
  typedef logic [15:0] angle_t;
  typedef enum logic [1:0] {
    FAULT_HIZ = 2'b00,
    FAULT_INPHASE = 2'b01,
    FAULT_NONE = 2'b10,
    FAULT_INPHASE_ALT = 2'b11
  } fault_mode_e;
  typedef enum logic [1:0] {
    ENC_IDLE = 2'b00,
    ENC_COUNTUP = 2'b01,
    ENC_TRACK = 2'b10,
    ENC_FAULT = 2'b11
  } enc_state_e;
endpackage : angle_postproc_pkg

// [core/turns_tracker.sv]
// quarter-turn counter with boundary hysteresis for one channel
// assumes angle samples on the same clock, direction already applied
`timescale 1ns/10ps
`default_nettype none
`include "angle_postproc_defs.svh"
module turns_tracker
  import angle_postproc_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample,
  input wire angle_t angle,
  input wire angle_t init_angle,
  input wire logic hyst_on,
  input wire logic init_sel,
  output logic [CNT_W-1:0] count_ff
);
  logic started_ff;
  logic [1:0] quad_ff;
  logic near_edge;
  logic [1:0] quad_step;

  // inside the dead band around a quadrant boundary
  assign near_edge = (angle[13:0] < `TURNS_BAND) ||
                     (angle[13:0] >= (14'h3FFF - `TURNS_BAND + 14'h0001));
  assign quad_step = angle[15:14] - quad_ff;

  // first sample initialises, later ones count boundary crossings
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      started_ff <= 1'b0;
      quad_ff <= 2'h0;
      count_ff <= '0;
    end
    else if (sample && !started_ff)
    begin
      started_ff <= 1'b1;
      quad_ff <= angle[15:14];
      count_ff <= init_sel ? CNT_W'(init_angle[15:14]) : '0;
    end
    else if (sample && (!hyst_on || !near_edge))
    begin
      quad_ff <= angle[15:14];
      if (quad_step == 2'h1)
        count_ff <= count_ff + 1'b1;
      else if (quad_step == 2'h3)
        count_ff <= count_ff - 1'b1;
    end
  end

  a_turns_band_hold: assert property (@(posedge clk) disable iff (rst)
    sample && started_ff && hyst_on && near_edge |=> $stable(count_ff))
    else $error("turns count moved inside hysteresis band");
  a_turns_init: assert property (@(posedge clk) disable iff (rst)
    sample && !started_ff |=>
      count_ff == ($past(init_sel) ? CNT_W'($past(init_angle[15:14])) : '0))
    else $error("turns count started at wrong value");
endmodule : turns_tracker
`default_nettype wire

// [core/angle_postproc.sv]
// angle post-processing: configuration registers on avalon-mm, direction,
// offset, turns counting, encoder slew/hysteresis/fault report, motion
// assumes angle samples, fault and slew setting come from same-clock logic
`timescale 1ns/10ps
`default_nettype none
`include "angle_postproc_defs.svh"
// Summary of operation
// - turns count frozen within 5.625 deg of quadrant boundaries when hysteresis on
// - secondary turns hysteresis applied when its off bit is clear
// - count-up report bit enables the count-up completion frame request
// - zero encoder slew setting disables count-up entirely
// - slew delay bit restarts encoder from zero at start-up and after fault
// - fault mode: 0 high-z, 1 and 3 in phase, 2 no report
// - encoder hysteresis threshold is 2 to the (setting+1) angle lsb
// - clock scale field sets assumed serial clock for motion scaling
// - motion channel bit picks primary (0) or secondary (1) angle
// - calibration active on primary only, off when disable bit set
// - sleep interval field sets low-power turns tracking sleep time
// - primary linearization enabled when its bit is one
// - turns count starts at 0 or at the primary quadrant number
// - direction bit zero counts counter-clockwise, one clockwise
// - each channel adds its offset times 360/4096 deg to its angle
// - spare bits are stored and affect no output
// - acceleration period 8.192, 1.024, 2.048 or 4.096 ms by selection
module angle_postproc
  import angle_postproc_pkg::*;
#(
  parameter int TICK_CYCLES = `ACC_BASE_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int TURNS_W = 16,
  parameter logic [15:0] ENC_STEP = 16'h0010
)(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [15:0] PRIM_ANGLE_IN,
  input wire logic [15:0] SEC_ANGLE_IN,
  input wire logic ANGLE_STROBE,
  input wire logic FAULT,
  input wire logic [5:0] ENC_SLEW_SETTING,
  output logic [15:0] PRIM_ANGLE_OUT,
  output logic [15:0] SEC_ANGLE_OUT,
  output logic [TURNS_W-1:0] PRIM_TURNS,
  output logic [TURNS_W-1:0] SEC_TURNS,
  output logic ENC_A,
  output logic ENC_B,
  output logic ENC_OE_N,
  output logic COUNTUP_DONE,
  output logic [15:0] VELOCITY,
  output logic [15:0] ACCEL,
  output logic CAL_ENABLE,
  output logic PRIM_LIN_ENABLE,
  output logic [3:0] SLEEP_INTERVAL
);
  localparam int TW = $clog2(TICK_CYCLES);

  // turns status word reads sixteen bits of each counter
  if (TICK_CYCLES < 2 || TURNS_W < 16 || ENC_STEP == 16'h0000)
  begin : g_bad_param
    $error("angle_postproc: parameter out of range");
  end

  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [25:0] enc_report_ff, prim_cfg_ff, sec_cfg_ff, sec_lin_low_ff;
  logic [7:0] idx;
  logic wr_take;
  logic out_valid_ff;
  logic cal_en_ff, lin_en_ff;
  logic [3:0] sleep_ff;
  enc_state_e enc_state_ff;
  angle_t enc_target_ff, enc_pos_ff;
  logic [5:0] slew_cnt_ff;
  logic slew_tick;
  logic enc_a_ff, enc_b_ff, enc_oe_n_ff, countup_done_ff;
  logic [TW-1:0] tick_cnt_ff;
  logic [2:0] acc_div_ff;
  angle_t motion_last_ff, vel_ff, vel_ref_ff, acc_ff;
  angle_t motion_src, vel_raw;
  logic [16:0] hyst_thr;
  logic [1:0] enc_quad;
  fault_mode_e fault_mode;

  // merge write data into a 26-bit register under byte enables
  function automatic logic [25:0] merge_be(input logic [25:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = {6'h00, old};
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    return res[25:0];
  endfunction : merge_be

  // direction then offset, wrapping at a full turn
  function automatic angle_t apply_cfg(input angle_t raw, input logic dir,
                                       input logic [10:0] offs);
    angle_t dirv;
    dirv = dir ? angle_t'(16'h0000 - raw) : raw;
    return angle_t'(dirv + {1'b0, offs, 4'h0});
  endfunction : apply_cfg

  // magnitude of a wrapped angle difference
  function automatic logic [16:0] wrap_mag(input angle_t a, input angle_t b);
    angle_t d;
    d = angle_t'(a - b);
    return d[15] ? {1'b0, angle_t'(16'h0000 - d)} : {1'b0, d};
  endfunction : wrap_mag

  // one slew step of the encoder position toward its target
  function automatic angle_t step_toward(input angle_t pos, input angle_t tgt);
    angle_t d;
    d = angle_t'(tgt - pos);
    if (wrap_mag(tgt, pos) <= {1'b0, ENC_STEP})
      return tgt;
    return d[15] ? angle_t'(pos - ENC_STEP) : angle_t'(pos + ENC_STEP);
  endfunction : step_toward

  // motion value scaled to the declared serial clock
  function automatic angle_t scale_motion(input angle_t v, input logic [2:0] sel);
    logic [2:0] sh;
    sh = `CLK_SCALE_REF - sel;
    return angle_t'($signed(v) >>> sh);
  endfunction : scale_motion

  // acceleration period in base ticks, minus one
  function automatic logic [2:0] acc_len_m1(input logic [1:0] sel);
    unique case (sel)
      2'h0: return 3'h7;
      2'h1: return 3'h0;
      2'h2: return 3'h1;
      2'h3: return 3'h3;
    endcase
  endfunction : acc_len_m1

  assign idx = AVS_ADDRESS[9:2];
  assign wr_take = AVS_WRITE && !wait_ff;

  // one-wait-state answer to every read or write
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      wait_ff <= 1'b1;
    else if ((AVS_READ || AVS_WRITE) && wait_ff)
      wait_ff <= 1'b0;
    else
      wait_ff <= 1'b1;
  end

  // read data captured as the wait state is dropped
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      rdata_ff <= 32'h00000000;
    else if (AVS_READ && wait_ff)
    begin
      unique case (idx)
        `IDX_SEC_LIN_LOW: rdata_ff <= {6'h00, sec_lin_low_ff};
        `IDX_ENC_REPORT: rdata_ff <= {6'h00, enc_report_ff};
        `IDX_PRIM_CFG: rdata_ff <= {6'h00, prim_cfg_ff};
        `IDX_SEC_CFG: rdata_ff <= {6'h00, sec_cfg_ff};
        `IDX_TURNS_STAT: rdata_ff <= {SEC_TURNS[15:0], PRIM_TURNS[15:0]};
        `IDX_ENC_STAT: rdata_ff <= {28'h0000000, FAULT, enc_state_ff, out_valid_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end

  // configuration registers; spare bits only stored and read back
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      enc_report_ff <= `CFG_RESET;
      prim_cfg_ff <= `CFG_RESET;
      sec_cfg_ff <= `CFG_RESET;
      sec_lin_low_ff <= `CFG_RESET;
    end
    else if (wr_take)
    begin
      if (idx == `IDX_ENC_REPORT)
        enc_report_ff <= merge_be(enc_report_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (idx == `IDX_PRIM_CFG)
        prim_cfg_ff <= merge_be(prim_cfg_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (idx == `IDX_SEC_CFG)
        sec_cfg_ff <= merge_be(sec_cfg_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (idx == `IDX_SEC_LIN_LOW)
        sec_lin_low_ff <= merge_be(sec_lin_low_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
    end
  end

  // control lines to the calibration, linearization and low-power logic
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cal_en_ff <= 1'b1;
      lin_en_ff <= 1'b0;
      sleep_ff <= 4'h0;
    end
    else
    begin
      cal_en_ff <= !prim_cfg_ff[`F_CAL_OFF];
      lin_en_ff <= prim_cfg_ff[`F_LIN_ON];
      sleep_ff <= prim_cfg_ff[`F_SLEEP];
    end
  end

  // direction and offset per channel on each new sample
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      PRIM_ANGLE_OUT <= 16'h0000;
      SEC_ANGLE_OUT <= 16'h0000;
      out_valid_ff <= 1'b0;
    end
    else
    begin
      out_valid_ff <= ANGLE_STROBE;
      if (ANGLE_STROBE)
      begin
        PRIM_ANGLE_OUT <= apply_cfg(PRIM_ANGLE_IN, prim_cfg_ff[`F_DIR],
                                    prim_cfg_ff[`F_OFFSET]);
        SEC_ANGLE_OUT <= apply_cfg(SEC_ANGLE_IN, sec_cfg_ff[`F_DIR],
                                   sec_cfg_ff[`F_OFFSET]);
      end
    end
  end

  // turns counters follow the processed angles; init from primary angle
  turns_tracker #(.CNT_W(TURNS_W)) u_prim_turns (
    .clk(REF_CLK),
    .rst(RESET),
    .sample(out_valid_ff),
    .angle(PRIM_ANGLE_OUT),
    .init_angle(PRIM_ANGLE_OUT),
    .hyst_on(1'b1),
    .init_sel(prim_cfg_ff[`F_INIT_SEL]),
    .count_ff(PRIM_TURNS)
  );
  turns_tracker #(.CNT_W(TURNS_W)) u_sec_turns (
    .clk(REF_CLK),
    .rst(RESET),
    .sample(out_valid_ff),
    .angle(SEC_ANGLE_OUT),
    .init_angle(PRIM_ANGLE_OUT),
    .hyst_on(!sec_lin_low_ff[`F_SEC_HYST_OFF]),
    .init_sel(sec_cfg_ff[`F_INIT_SEL]),
    .count_ff(SEC_TURNS)
  );

  // slew divider: one tick per ENC_SLEW_SETTING cycles
  assign slew_tick = (ENC_SLEW_SETTING != 6'h00) &&
                     (slew_cnt_ff >= ENC_SLEW_SETTING - 6'h01);
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      slew_cnt_ff <= 6'h00;
    else if (slew_tick || ENC_SLEW_SETTING == 6'h00)
      slew_cnt_ff <= 6'h00;
    else
      slew_cnt_ff <= slew_cnt_ff + 6'h01;
  end

  // shift amount widened so setting 7 gives 2^8, not a wrapped 2^0
  assign hyst_thr = 17'h00001 << (4'(prim_cfg_ff[`F_ENCODER_ANGLE_HYSTERESIS]) + 4'h1);
  assign fault_mode = fault_mode_e'(enc_report_ff[`F_FAULT_MODE]);

  // encoder position: start-up, count-up, tracking and fault hold
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      enc_state_ff <= ENC_IDLE;
      enc_target_ff <= 16'h0000;
      enc_pos_ff <= 16'h0000;
      countup_done_ff <= 1'b0;
    end
    else
    begin
      countup_done_ff <= 1'b0;
      unique case (enc_state_ff)
        ENC_IDLE, ENC_FAULT:
        begin
          if (!FAULT && (out_valid_ff || enc_state_ff == ENC_FAULT))
          begin
            enc_target_ff <= PRIM_ANGLE_OUT;
            if (enc_report_ff[`F_SLEW_DLY] && ENC_SLEW_SETTING != 6'h00)
            begin
              enc_pos_ff <= 16'h0000;
              enc_state_ff <= ENC_COUNTUP;
            end
            else
            begin
              enc_pos_ff <= PRIM_ANGLE_OUT;
              enc_state_ff <= ENC_TRACK;
            end
          end
        end
        ENC_COUNTUP, ENC_TRACK:
        begin
          if (FAULT)
            enc_state_ff <= ENC_FAULT;
          else
          begin
            if (wrap_mag(PRIM_ANGLE_OUT, enc_target_ff) >= hyst_thr)
              enc_target_ff <= PRIM_ANGLE_OUT;
            if (ENC_SLEW_SETTING == 6'h00)
              enc_pos_ff <= enc_target_ff;
            else if (slew_tick)
              enc_pos_ff <= step_toward(enc_pos_ff, enc_target_ff);
            if (enc_state_ff == ENC_COUNTUP &&
                (enc_pos_ff == enc_target_ff || ENC_SLEW_SETTING == 6'h00))
            begin
              enc_state_ff <= ENC_TRACK;
              countup_done_ff <= enc_report_ff[`F_COUNTUP_RPT] &&
                                 ENC_SLEW_SETTING != 6'h00;
            end
          end
        end
      endcase
    end
  end

  // quadrature pins with fault reporting
  assign enc_quad = enc_pos_ff[5:4];
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      enc_a_ff <= 1'b0;
      enc_b_ff <= 1'b0;
      enc_oe_n_ff <= 1'b1;
    end
    else if (FAULT && fault_mode == FAULT_HIZ)
      enc_oe_n_ff <= 1'b1;
    else if (FAULT && fault_mode != FAULT_NONE)
    begin
      enc_a_ff <= 1'b1;
      enc_b_ff <= 1'b1;
      enc_oe_n_ff <= 1'b0;
    end
    else
    begin
      enc_a_ff <= enc_quad[1];
      enc_b_ff <= enc_quad[1] ^ enc_quad[0];
      enc_oe_n_ff <= (enc_state_ff == ENC_IDLE);
    end
  end

  // base tick and acceleration period divider
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      tick_cnt_ff <= '0;
      acc_div_ff <= 3'h0;
    end
    else if (tick_cnt_ff == TW'(TICK_CYCLES - 1))
    begin
      tick_cnt_ff <= '0;
      if (acc_div_ff >= acc_len_m1(sec_cfg_ff[`F_ACC_RATE]))
        acc_div_ff <= 3'h0;
      else
        acc_div_ff <= acc_div_ff + 3'h1;
    end
    else
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
  end

  // velocity per base tick and acceleration per selected period
  assign motion_src = prim_cfg_ff[`F_MOTION_SEL] ? SEC_ANGLE_OUT : PRIM_ANGLE_OUT;
  assign vel_raw = scale_motion(angle_t'(motion_src - motion_last_ff),
                                prim_cfg_ff[`F_CLK_SCALE]);
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      motion_last_ff <= 16'h0000;
      vel_ff <= 16'h0000;
      vel_ref_ff <= 16'h0000;
      acc_ff <= 16'h0000;
    end
    else if (tick_cnt_ff == TW'(TICK_CYCLES - 1))
    begin
      motion_last_ff <= motion_src;
      vel_ff <= vel_raw;
      if (acc_div_ff >= acc_len_m1(sec_cfg_ff[`F_ACC_RATE]))
      begin
        acc_ff <= angle_t'(vel_raw - vel_ref_ff);
        vel_ref_ff <= vel_raw;
      end
    end
  end

  assign AVS_WAITREQUEST = wait_ff;
  assign AVS_READDATA = rdata_ff;
  assign ENC_A = enc_a_ff;
  assign ENC_B = enc_b_ff;
  assign ENC_OE_N = enc_oe_n_ff;
  assign COUNTUP_DONE = countup_done_ff;
  assign VELOCITY = vel_ff;
  assign ACCEL = acc_ff;
  assign CAL_ENABLE = cal_en_ff;
  assign PRIM_LIN_ENABLE = lin_en_ff;
  assign SLEEP_INTERVAL = sleep_ff;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_bus_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  a_bus_answer: assert property (s_bus_req |=> !AVS_WAITREQUEST)
    else $error("bus request not answered in one cycle");
  a_fault_hiz: assert property (FAULT && fault_mode == FAULT_HIZ |=> ENC_OE_N)
    else $error("encoder not released in high-z fault mode");
  a_fault_inphase: assert property (
    FAULT && enc_report_ff[22] |=> ENC_A && ENC_B && !ENC_OE_N)
    else $error("encoder not in phase during fault");
  a_countup_gate: assert property (
    COUNTUP_DONE |-> $past(enc_report_ff[`F_COUNTUP_RPT]) &&
                     $past(ENC_SLEW_SETTING) != 6'h00)
    else $error("count-up report without enable");
  a_prim_offset: assert property (ANGLE_STROBE |=>
    PRIM_ANGLE_OUT == apply_cfg($past(PRIM_ANGLE_IN), $past(prim_cfg_ff[11]),
                                $past(prim_cfg_ff[10:0])))
    else $error("primary angle offset or direction wrong");
  a_cal_off: assert property (
    wr_take && idx == `IDX_PRIM_CFG && AVS_BYTEENABLE[2] && AVS_WRITEDATA[18]
    |=> ##1 !CAL_ENABLE)
    else $error("calibration still enabled after disable");
  a_enc_hyst: assert property (
    enc_state_ff == ENC_TRACK && !FAULT && $changed(PRIM_ANGLE_OUT)
    && wrap_mag(PRIM_ANGLE_OUT, enc_target_ff) < hyst_thr |=> $stable(enc_target_ff))
    else $error("encoder target moved below hysteresis");
endmodule : angle_postproc
`default_nettype wire

// [test/enc_host_model.sv]
// host-side encoder reader: counts quadrature pin changes while driven
// assumes pins on the same clock; released pins are not counted
`timescale 1ns/10ps
`default_nettype none
module enc_host_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_oe_n,
  input wire logic [15:0] vel,
  output logic [15:0] edges_ff,
  output logic [15:0] host_vel
);
  logic [1:0] last_ff;
  logic was_on_ff;
  // count changes only between two driven samples
  always_ff @(posedge clk)
  begin
    last_ff <= {enc_a, enc_b};
    was_on_ff <= !enc_oe_n;
    if (clr)
      edges_ff <= '0;
    else if (!enc_oe_n && was_on_ff && {enc_a, enc_b} != last_ff)
      edges_ff <= edges_ff + 16'h0001;
  end
  // real serial clock equals the declared one, so the scale is one
  assign host_vel = vel;
endmodule : enc_host_model
`default_nettype wire

// [test/angle_postproc_test.sv]
// self-checking bench for the angle post-processing block
// assumes a 20 MHz clock and a shortened acceleration tick
`timescale 1ns/10ps
`default_nettype none
module angle_postproc_test
  import angle_postproc_pkg::*;
;
  logic clk, rst, rd, wr, stb, fault, done, oe_n, ea, eb, cal, lin, wreq, clr, seen;
  logic [9:0] addr;
  logic [31:0] wd, rdata, got;
  logic [3:0] be, sleep;
  logic [15:0] pin, sin, pout, sout, pt, st, vel, hvel, edges, acc;
  logic [5:0] slew;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  // index, lanes, write data, expected readback
  localparam logic [75:0] ROWS [6] = '{
    {8'h3D, 4'hF, 32'hFFFFFFFF, 32'h03FFFFFF},
    {8'h3D, 4'h1, 32'h00000000, 32'h03FFFF00},
    {8'h3E, 4'hF, 32'hFFFFFFFF, 32'h03FFFFFF},
    {8'h3F, 4'hF, 32'hFFFFFFFF, 32'h03FFFFFF},
    {8'h32, 4'hF, 32'hFFFFFFFF, 32'h03FFFFFF},
    {8'h10, 4'hF, 32'hFFFFFFFF, 32'h00000000}};

  angle_postproc #(.TICK_CYCLES(8)) dut (
    .REF_CLK(clk), .RESET(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .PRIM_ANGLE_IN(pin), .SEC_ANGLE_IN(sin), .ANGLE_STROBE(stb), .FAULT(fault),
    .ENC_SLEW_SETTING(slew), .PRIM_ANGLE_OUT(pout), .SEC_ANGLE_OUT(sout),
    .PRIM_TURNS(pt), .SEC_TURNS(st), .ENC_A(ea), .ENC_B(eb), .ENC_OE_N(oe_n),
    .COUNTUP_DONE(done), .VELOCITY(vel), .ACCEL(acc), .CAL_ENABLE(cal),
    .PRIM_LIN_ENABLE(lin), .SLEEP_INTERVAL(sleep));

  enc_host_model host (.clk(clk), .clr(clr), .enc_a(ea), .enc_b(eb), .enc_oe_n(oe_n),
    .vel(vel), .edges_ff(edges), .host_vel(hvel));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [3:0] b,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wd <= d;
    be <= b;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic strobe(input logic [15:0] p, input logic [15:0] s);
    @(posedge clk);
    pin <= p;
    sin <= s;
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : strobe

  // fault pulse then watch for the count-up completion pulse
  task automatic cu(input logic [31:0] cfg, input logic [5:0] s, input logic e);
    bus(1'b1, 8'h3D, 4'hF, cfg);
    slew <= s;
    clr <= 1'b1;
    fault <= 1'b1;
    repeat (4) @(posedge clk);
    clr <= 1'b0;
    fault <= 1'b0;
    seen = 1'b0;
    repeat (400)
    begin
      @(posedge clk);
      #1;
      if (done === 1'b1)
        seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, e});
  endtask : cu

  // new config and angle pair, then first nonzero velocity and acceleration seen
  task automatic mot(input logic [31:0] pc, input logic [31:0] sc, input logic [15:0] p,
                     input logic [15:0] s, input logic [15:0] ev, input logic [15:0] ea);
    logic [15:0] gv, ga;
    bus(1'b1, 8'h3E, 4'hF, pc);
    bus(1'b1, 8'h3F, 4'hF, sc);
    repeat (32) @(posedge clk);
    strobe(p, s);
    gv = 16'h0000;
    ga = 16'h0000;
    repeat (24)
    begin
      @(posedge clk);
      #1;
      if (gv === 16'h0000)
        gv = hvel;
      if (ga === 16'h0000)
        ga = acc;
    end
    chk({gv, ga}, {ev, ea});
  endtask : mot

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      mismatches++;
      stop_test;
    end
  end

  initial
  begin
    {rst, rd, wr, stb, fault, clr} = 6'h20;
    {addr, wd, be, pin, sin} = '0;
    slew = 6'h02;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({30'h0, cal, oe_n}, 32'h00000003);
    bus(1'b0, 8'h3E, 4'hF, '0);
    chk(got, 32'h00000000);
    foreach (ROWS[i])
    begin
      bus(1'b1, ROWS[i][75:68], ROWS[i][67:64], ROWS[i][63:32]);
      bus(1'b0, ROWS[i][75:68], 4'hF, '0);
      chk(got, ROWS[i][31:0]);
    end
    chk({26'h0, cal, lin, sleep}, 32'h0000001F);
    // both channels get the same init and direction settings
    bus(1'b1, 8'h3E, 4'hF, 32'h00001000);
    bus(1'b1, 8'h3F, 4'hF, 32'h00001000);
    bus(1'b1, 8'h3D, 4'hF, 32'h00000000);
    strobe(16'h9000, 16'h9000);
    chk({pt, st}, 32'h00020002);
    // secondary hysteresis off: its bit was set by the all-ones row
    strobe(16'hC200, 16'hC200);
    chk({pt, st}, 32'h00020003);
    strobe(16'hC800, 16'hC800);
    chk({pt, st}, 32'h00030003);
    strobe(16'hB000, 16'hB000);
    chk({pt, st}, 32'h00020002);
    bus(1'b1, 8'h3E, 4'hF, 32'h00001810);
    bus(1'b1, 8'h3F, 4'hF, 32'h00001800);
    strobe(16'h1000, 16'h2000);
    chk({pout, sout}, 32'hF100E000);
    bus(1'b1, 8'h3E, 4'hF, 32'h00001010);
    bus(1'b1, 8'h3F, 4'hF, 32'h00001000);
    strobe(16'h0300, 16'h0300);
    chk({pout, sout}, 32'h04000300);
    // high-z mode last, so the pins it holds are known
    for (int m = 1; m < 5; m++)
    begin
      bus(1'b1, 8'h3D, 4'hF, 32'(m % 4) << 22);
      fault <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk({30'h0, oe_n, ea & eb}, {30'h0, m == 4, m[0]});
      @(posedge clk);
      fault <= 1'b0;
    end
    cu(32'h03000000, 6'h02, 1'b1);
    chk({16'h0, edges}, 32'h0400 / 32'h0010);
    cu(32'h01000000, 6'h02, 1'b0);
    cu(32'h03000000, 6'h00, 1'b0);
    bus(1'b1, 8'h3E, 4'hF, 32'h03801000);
    slew <= 6'h02;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    strobe(16'h04F0, 16'h04F0);
    repeat (50) @(posedge clk);
    chk({16'h0, edges}, 32'h00000000);
    strobe(16'h0520, 16'h0520);
    repeat (100) @(posedge clk);
    chk({31'h0, edges != 16'h0000}, 32'h00000001);
    // motion: scale 7 and 6 on primary, then secondary selected
    mot(32'h00700000, 32'h00040000, 16'h0620, 16'h0520, 16'h0100, 16'h0100);
    mot(32'h00600000, 32'h00040000, 16'h0820, 16'h0520, 16'h0100, 16'h0100);
    mot(32'h00700200, 32'h00040000, 16'h0A20, 16'h0540, 16'h0020, 16'h0020);
    // second reset: turns start at zero with init select clear
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({pt, st}, 32'h00000000);
    chk({30'h0, cal, oe_n}, 32'h00000003);
    strobe(16'hC800, 16'hC800);
    chk({pt, st}, 32'h00000000);
    strobe(16'h0200, 16'h0200);
    chk({pt, st}, 32'h00000000);
    stop_test;
  end
endmodule : angle_postproc_test
`default_nettype wire
